// ==== include/ptf_pkg.sv ====
package ptf_pkg;

   // ----------------------------------------------------------------
   // Bus map
   // ----------------------------------------------------------------
   localparam logic [7:0] WIPE_LEN_ADDR  = 8'h00;
   localparam logic [7:0] TRAIN_LOW_ADDR = 8'h04;
   localparam logic [7:0] TRAIN_HIGH_ADDR = 8'h08;
   localparam logic [7:0] TRAIN_CNT_ADDR = 8'h0C;
   localparam logic [7:0] GEN_HIGH_ADDR  = 8'h10;
   localparam logic [7:0] GEN_LOW_ADDR   = 8'h14;
   localparam logic [7:0] CTRL_ADDR      = 8'h18;
   localparam logic [7:0] STATUS_ADDR    = 8'h1C;
   localparam logic [7:0] WIPE_ET_ADDR   = 8'h20;
   localparam logic [7:0] TRAIN_ET_ADDR  = 8'h24;
   localparam logic [7:0] GEN_ET_ADDR    = 8'h28;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int CTRL_RET_WIPE  = 0;
   localparam int CTRL_RET_TRAIN = 1;
   localparam int CTRL_RET_GEN   = 2;
   localparam int CTRL_SRC_LO    = 4;
   localparam int SRC_FIELD_W    = 4;
   localparam int SRC_FIELDS     = 5;
   localparam int SEL_W          = 2;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] TIME_RESET   = 16'h000A;
   localparam logic [3:0]  CNT_MIN      = 4'h1;
   localparam logic [3:0]  CNT_MAX      = 4'h9;
   localparam logic [3:0]  CNT_RESET    = 4'h1;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ    = 125_000_000;
   localparam int TICK_HZ   = 100;
   localparam int TICK_DIV  = CLK_HZ / TICK_HZ;

   typedef enum logic [1:0] {
      TR_IDLE,
      TR_LOW,
      TR_HIGH
   } ptf_train_state_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } ptf_apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ptf_apb_rsp_type;

endpackage

// ==== hw/ptf_pulse_timers.sv ====
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
// Operation
// - Wipe trigger rise sets output, clears time
// - Wipe output drops when time reaches length
// - Wipe trigger fall ends pulse at once
// - Per-block retention keeps output and time
// - Time parameters may follow another block
// - Train trigger rise starts low, then high
// - Train repeats count times, one to nine
// - Retrigger inside cycle restarts from zero
// - Train clear zeroes time, output low
// - Generator runs only while gate active
// - Generator alternates high then low widths
// - Inversion acts only while gate active
module ptf_pulse_timers
   import ptf_pkg::*;
#(
   parameter int TW       = 16,
   parameter int TICK_CNT = TICK_DIV
) (
   input  wire logic            ref_clk_i,
   input  wire logic            rst_n_i,
   input  wire logic            pwr_ok_i,
   input  wire ptf_apb_req_type apb_req_i,
   output ptf_apb_rsp_type      apb_rsp_o,
   input  wire logic            wipe_trig_i,
   input  wire logic            train_trig_i,
   input  wire logic            train_clear_i,
   input  wire logic            gen_gate_i,
   input  wire logic            gen_invert_i,
   input  wire logic [TW-1:0]   ext_time_i,
   output logic                 wipe_q_o,
   output logic                 train_q_o,
   output logic                 gen_q_o,
   output logic [TW-1:0]        wipe_elapsed_time_o,
   output logic [TW-1:0]        train_elapsed_time_o,
   output logic [TW-1:0]        gen_elapsed_time_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]         tick_div;
      logic                tick;
      logic [TW-1:0]       wipe_len;
      logic [TW-1:0]       train_low;
      logic [TW-1:0]       train_high;
      logic [3:0]          train_cnt;
      logic [TW-1:0]       gen_high;
      logic [TW-1:0]       gen_low;
      logic [31:0]         ctrl;
      logic                wipe_trig_d;
      logic                train_trig_d;
      logic                wipe_q;
      logic [TW-1:0]       wipe_elapsed_time;
      ptf_train_state_type train_st;
      logic [3:0]          train_done;
      logic [TW-1:0]       train_elapsed_time;
      logic                gen_high_ph;
      logic [TW-1:0]       gen_elapsed_time;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } ptf_state_type;

   ptf_state_type st_reg;
   ptf_state_type st_next;

   // Sized increment keeps the time adders at their own width
   localparam logic [TW-1:0] T_ONE = TW'(1);

   // Picks a constant or another block's actual value per time input
   function automatic logic [TW-1:0] pick_time(
      input logic [SRC_FIELD_W-1:0] src,
      input logic [TW-1:0]          konst,
      input logic [TW-1:0]          ext,
      input logic [TW-1:0]          a0,
      input logic [TW-1:0]          a1,
      input logic [TW-1:0]          a2
   );
      logic [TW-1:0] v;
      v = konst;
      case (src[SEL_W-1:0])
         2'h1:    v = a0;
         2'h2:    v = a1;
         2'h3:    v = a2;
         default: v = konst;
      endcase
      if (src[SEL_W])
         v = ext;
      return v;
   endfunction

   function automatic logic [3:0] clamp_cnt(input logic [31:0] d);
      logic [3:0] c;
      c = d[3:0];
      if (d[31:4] != 28'h0 || c > CNT_MAX)
         c = CNT_MAX;
      else if (c < CNT_MIN)
         c = CNT_MIN;
      return c;
   endfunction

   // ----------------------------------------------------------------
   // Effective times
   // ----------------------------------------------------------------
   logic [TW-1:0] eff [SRC_FIELDS];
   logic [TW-1:0] konst [SRC_FIELDS];

   always_comb begin
      konst[0] = st_reg.wipe_len;
      konst[1] = st_reg.train_low;
      konst[2] = st_reg.train_high;
      konst[3] = st_reg.gen_high;
      konst[4] = st_reg.gen_low;
   end

   generate
      for (genvar i = 0; i < SRC_FIELDS; i++) begin : g_src
         always_comb begin
            eff[i] = pick_time(
               st_reg.ctrl[CTRL_SRC_LO + i*SRC_FIELD_W +: SRC_FIELD_W],
               konst[i], ext_time_i, st_reg.wipe_elapsed_time,
               st_reg.train_elapsed_time, st_reg.gen_elapsed_time);
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic wipe_rise;
   logic wipe_fall;
   logic train_rise;
   logic apb_access;
   logic [TW-1:0] t_next;

   always_comb begin
      st_next    = st_reg;
      wipe_rise  = wipe_trig_i && !st_reg.wipe_trig_d;
      wipe_fall  = !wipe_trig_i && st_reg.wipe_trig_d;
      train_rise = train_trig_i && !st_reg.train_trig_d;
      apb_access = apb_req_i.psel && apb_req_i.penable;
      t_next     = '0;

      // Program-cycle tick divider
      st_next.tick = 1'b0;
      if (st_reg.tick_div >= 32'(TICK_CNT - 1)) begin
         st_next.tick_div = 32'h0;
         st_next.tick     = 1'b1;
      end else begin
         st_next.tick_div = st_reg.tick_div + 32'h1;
      end

      st_next.wipe_trig_d  = wipe_trig_i;
      st_next.train_trig_d = train_trig_i;

      // Single-pulse block
      if (wipe_rise) begin
         st_next.wipe_q            = 1'b1;
         st_next.wipe_elapsed_time = '0;
      end else if (wipe_fall) begin
         st_next.wipe_q = 1'b0;
      end else if (st_reg.wipe_q) begin
         if (st_reg.wipe_elapsed_time >= eff[0])
            st_next.wipe_q = 1'b0;
         else if (st_reg.tick) begin
            t_next = st_reg.wipe_elapsed_time + T_ONE;
            st_next.wipe_elapsed_time = t_next;
            if (t_next >= eff[0])
               st_next.wipe_q = 1'b0;
         end
      end

      // Pulse-train block
      if (train_clear_i) begin
         st_next.train_st           = TR_IDLE;
         st_next.train_elapsed_time = '0;
         st_next.train_done         = 4'h0;
      end else if (train_rise) begin
         st_next.train_st           = TR_LOW;
         st_next.train_elapsed_time = '0;
         st_next.train_done         = 4'h0;
      end else if (st_reg.tick) begin
         case (st_reg.train_st)
            TR_LOW: begin
               if (st_reg.train_elapsed_time + T_ONE >= eff[1]) begin
                  st_next.train_st           = TR_HIGH;
                  st_next.train_elapsed_time = '0;
               end else begin
                  st_next.train_elapsed_time =
                     st_reg.train_elapsed_time + T_ONE;
               end
            end
            TR_HIGH: begin
               if (st_reg.train_elapsed_time + T_ONE >= eff[2]) begin
                  st_next.train_elapsed_time = '0;
                  st_next.train_done = st_reg.train_done + 4'h1;
                  if (st_reg.train_done + 4'h1 >= st_reg.train_cnt)
                     st_next.train_st = TR_IDLE;
                  else
                     st_next.train_st = TR_LOW;
               end else begin
                  st_next.train_elapsed_time =
                     st_reg.train_elapsed_time + T_ONE;
               end
            end
            default: st_next.train_st = TR_IDLE;
         endcase
      end

      // Free-running generator
      if (!gen_gate_i) begin
         st_next.gen_high_ph      = 1'b1;
         st_next.gen_elapsed_time = '0;
      end else if (st_reg.tick) begin
         t_next = st_reg.gen_elapsed_time + T_ONE;
         if (t_next >= (st_reg.gen_high_ph ? eff[3] : eff[4])) begin
            st_next.gen_high_ph      = !st_reg.gen_high_ph;
            st_next.gen_elapsed_time = '0;
         end else begin
            st_next.gen_elapsed_time = t_next;
         end
      end

      // APB slave, answers in the access cycle with no wait
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      if (apb_req_i.psel && !apb_req_i.penable) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0;
         case (apb_req_i.paddr)
            WIPE_LEN_ADDR:   st_next.prdata = 32'(st_reg.wipe_len);
            TRAIN_LOW_ADDR:  st_next.prdata = 32'(st_reg.train_low);
            TRAIN_HIGH_ADDR: st_next.prdata = 32'(st_reg.train_high);
            TRAIN_CNT_ADDR:  st_next.prdata = 32'(st_reg.train_cnt);
            GEN_HIGH_ADDR:   st_next.prdata = 32'(st_reg.gen_high);
            GEN_LOW_ADDR:    st_next.prdata = 32'(st_reg.gen_low);
            CTRL_ADDR:       st_next.prdata = st_reg.ctrl;
            STATUS_ADDR:     st_next.prdata = {29'h0, gen_q_o,
                                   st_reg.train_st == TR_HIGH,
                                   st_reg.wipe_q};
            WIPE_ET_ADDR:    st_next.prdata =
                                32'(st_reg.wipe_elapsed_time);
            TRAIN_ET_ADDR:   st_next.prdata =
                                32'(st_reg.train_elapsed_time);
            GEN_ET_ADDR:     st_next.prdata =
                                32'(st_reg.gen_elapsed_time);
            default:         st_next.pslverr = 1'b1;
         endcase
      end
      if (apb_access && st_reg.pready && apb_req_i.pwrite &&
          !st_reg.pslverr) begin
         case (apb_req_i.paddr)
            WIPE_LEN_ADDR:   st_next.wipe_len   = apb_req_i.pwdata[TW-1:0];
            TRAIN_LOW_ADDR:  st_next.train_low  = apb_req_i.pwdata[TW-1:0];
            TRAIN_HIGH_ADDR: st_next.train_high = apb_req_i.pwdata[TW-1:0];
            TRAIN_CNT_ADDR:  st_next.train_cnt  =
                                clamp_cnt(apb_req_i.pwdata);
            GEN_HIGH_ADDR:   st_next.gen_high   = apb_req_i.pwdata[TW-1:0];
            GEN_LOW_ADDR:    st_next.gen_low    = apb_req_i.pwdata[TW-1:0];
            CTRL_ADDR:       st_next.ctrl       = apb_req_i.pwdata;
            default:         st_next.ctrl       = st_reg.ctrl;
         endcase
      end

      // Power loss clears non-retentive blocks; retentive ones hold
      if (!pwr_ok_i) begin
         if (!st_reg.ctrl[CTRL_RET_WIPE]) begin
            st_next.wipe_q            = 1'b0;
            st_next.wipe_elapsed_time = '0;
         end
         if (!st_reg.ctrl[CTRL_RET_TRAIN]) begin
            st_next.train_st           = TR_IDLE;
            st_next.train_elapsed_time = '0;
            st_next.train_done         = 4'h0;
         end
         if (!st_reg.ctrl[CTRL_RET_GEN]) begin
            st_next.gen_high_ph      = 1'b1;
            st_next.gen_elapsed_time = '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg            <= '0;
         st_reg.wipe_len   <= TIME_RESET[TW-1:0];
         st_reg.train_low  <= TIME_RESET[TW-1:0];
         st_reg.train_high <= TIME_RESET[TW-1:0];
         st_reg.train_cnt  <= CNT_RESET;
         st_reg.gen_high   <= TIME_RESET[TW-1:0];
         st_reg.gen_low    <= TIME_RESET[TW-1:0];
         st_reg.ctrl       <= CTRL_RESET;
         st_reg.gen_high_ph <= 1'b1;
         st_reg.train_st   <= TR_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wipe_q_o  = st_reg.wipe_q;
   assign train_q_o = (st_reg.train_st == TR_HIGH);
   // Inversion only meaningful while gated on
   assign gen_q_o   = gen_gate_i &&
                      (st_reg.gen_high_ph ^ gen_invert_i);
   assign wipe_elapsed_time_o  = st_reg.wipe_elapsed_time;
   assign train_elapsed_time_o = st_reg.train_elapsed_time;
   assign gen_elapsed_time_o   = st_reg.gen_elapsed_time;
   assign apb_rsp_o.pready  = st_reg.pready;
   assign apb_rsp_o.pslverr = st_reg.pslverr;
   assign apb_rsp_o.prdata  = st_reg.prdata;

endmodule

// ==== dv/ptf_far_model.sv ====
`timescale 1ns/1ps
// ------
// Far block whose actual value feeds a time
// ------
module ptf_far_model (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        load_i,
   input  wire logic [15:0] value_i,
   output logic [15:0]      actual_o
);
   // Held between loads, like a stopped counter
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         actual_o <= 16'h0000;
      end else if (load_i) begin
         actual_o <= value_i;
      end
   end
endmodule

// ==== dv/ptf_pulse_timers_assertions.sv ====
`timescale 1ns/1ps
module ptf_pulse_timers_assertions
   import ptf_pkg::*;
#(
   parameter int TW = 16
) (
   input wire logic            ref_clk_i,
   input wire logic            rst_n_i,
   input wire logic            pwr_ok_i,
   input wire ptf_apb_req_type apb_req_i,
   input wire ptf_apb_rsp_type apb_rsp_o,
   input wire logic            wipe_trig_i,
   input wire logic            train_trig_i,
   input wire logic            train_clear_i,
   input wire logic            gen_gate_i,
   input wire logic            gen_invert_i,
   input wire logic [TW-1:0]   ext_time_i,
   input wire logic            wipe_q_o,
   input wire logic            train_q_o,
   input wire logic            gen_q_o,
   input wire logic [TW-1:0]   wipe_elapsed_time_o,
   input wire logic [TW-1:0]   train_elapsed_time_o,
   input wire logic [TW-1:0]   gen_elapsed_time_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Power-fail cycles excluded: restore may lag
   a_wipe_rise_set: assert property ($rose(wipe_trig_i) && pwr_ok_i
      |=> wipe_q_o && wipe_elapsed_time_o == '0)
      else $error("wipe pulse did not start");
   a_wipe_rise_cause: assert property ($rose(wipe_q_o)
      && $past(pwr_ok_i) |-> $past(wipe_trig_i) && !$past(wipe_trig_i, 2))
      else $error("wipe pulse without trigger edge");
   a_wipe_low_end: assert property (!wipe_trig_i && pwr_ok_i
      |=> !wipe_q_o)
      else $error("wipe pulse outlived trigger");
   a_train_rise_low: assert property ($rose(train_trig_i)
      && pwr_ok_i && !train_clear_i
      |=> !train_q_o && train_elapsed_time_o == '0)
      else $error("train did not restart low");
   a_train_clear_zero: assert property (train_clear_i
      |=> !train_q_o && train_elapsed_time_o == '0)
      else $error("train clear ignored");
   a_gen_gate_off: assert property (!gen_gate_i |-> !gen_q_o)
      else $error("generator drives while gated off");
   a_gen_start_high: assert property ($rose(gen_gate_i)
      |-> gen_q_o == !gen_invert_i)
      else $error("generator did not start high");
   a_gen_off_hold: assert property (!gen_gate_i && !$past(gen_gate_i)
      && !$past(gen_gate_i, 2) && pwr_ok_i && $past(pwr_ok_i)
      |-> $stable(gen_elapsed_time_o))
      else $error("generator time moved while gated off");
endmodule

bind ptf_pulse_timers ptf_pulse_timers_assertions #(.TW(TW)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pwr_ok_i(pwr_ok_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
   .wipe_trig_i(wipe_trig_i), .train_trig_i(train_trig_i),
   .train_clear_i(train_clear_i), .gen_gate_i(gen_gate_i),
   .gen_invert_i(gen_invert_i), .ext_time_i(ext_time_i),
   .wipe_q_o(wipe_q_o), .train_q_o(train_q_o), .gen_q_o(gen_q_o),
   .wipe_elapsed_time_o(wipe_elapsed_time_o),
   .train_elapsed_time_o(train_elapsed_time_o),
   .gen_elapsed_time_o(gen_elapsed_time_o));

// ==== dv/ptf_pulse_timers_tb.sv ====
`timescale 1ns/1ps
module ptf_pulse_timers_tb;
   import ptf_pkg::*;
   localparam int TK = 4;
   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            pok = 1'b1;
   ptf_apb_req_type req = '0;
   ptf_apb_rsp_type rsp;
   logic            wt = 1'b0;
   logic            tt = 1'b0;
   logic            tc = 1'b0;
   logic            gg = 1'b0;
   logic            gi = 1'b0;
   logic            ld = 1'b0;
   logic [15:0]     ldv = 16'h0000;
   logic [15:0]     ext, wet, tet, get;
   logic            wq, tq, gq;
   logic [31:0]     rd;
   logic [31:0]     cv[4] = '{32'h0, 32'hA, 32'hF, 32'h5};
   int              error_cnt = 0;
   int              n_compared = 0;
   int              seed = 32'hbc3c;
   int              n, m, len;
   always #4 clk = ~clk;
   ptf_far_model u_far (.ref_clk_i(clk), .rst_n_i(rst_n), .load_i(ld),
      .value_i(ldv), .actual_o(ext));
   ptf_pulse_timers #(.TICK_CNT(TK)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n),
      .pwr_ok_i(pok), .apb_req_i(req), .apb_rsp_o(rsp), .wipe_trig_i(wt),
      .train_trig_i(tt), .train_clear_i(tc), .gen_gate_i(gg),
      .gen_invert_i(gi), .ext_time_i(ext), .wipe_q_o(wq), .train_q_o(tq),
      .gen_q_o(gq), .wipe_elapsed_time_o(wet),
      .train_elapsed_time_o(tet), .gen_elapsed_time_o(get));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic hang;
      error_cnt++;
      print_verdict();
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic e);
      int i;
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      if (i >= 20) hang();
      rd = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] x,
                       input logic ee);
      logic e;
      apb(1'b0, a, 32'h0, e);
      chk({31'h0, e}, {31'h0, ee});
      if (!ee) chk(rd, x);
   endtask
   // Output picked by index: 0 wipe, 1 train, 2 generator
   function automatic logic out_sel(input int w);
      case (w)
         0: return wq;
         1: return tq;
         default: return gq;
      endcase
   endfunction
   // Bounded: a stuck output ends the run
   task automatic till(input int w, input logic v);
      int i;
      i = 0;
      while (out_sel(w) !== v && i < 500) begin
         @(posedge clk);
         i++;
      end
      if (i >= 500) hang();
   endtask
   task automatic run(input int w, input logic v, output int k);
      k = 0;
      while (out_sel(w) === v && k < 500) begin
         @(posedge clk);
         k++;
      end
      if (k >= 500) hang();
   endtask
   function automatic logic [31:0] cnt_exp(input logic [31:0] v);
      if (v[3:0] < CNT_MIN) return {28'h0, CNT_MIN};
      if (v[3:0] > CNT_MAX) return {28'h0, CNT_MAX};
      return {28'h0, v[3:0]};
   endfunction
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(1);
      rchk(WIPE_LEN_ADDR, {16'h0, TIME_RESET}, 1'b0);
      rchk(TRAIN_CNT_ADDR, {28'h0, CNT_RESET}, 1'b0);
      rchk(CTRL_ADDR, CTRL_RESET, 1'b0);
      rchk(8'h30, 32'h0, 1'b1);
      wr(STATUS_ADDR, 32'hFFFF_FFFF);
      rchk(STATUS_ADDR, 32'h0, 1'b0);
      foreach (cv[i]) begin
         wr(TRAIN_CNT_ADDR, cv[i]);
         rchk(TRAIN_CNT_ADDR, cnt_exp(cv[i]), 1'b0);
      end
      $display("Test registers done");
      // Last pass takes the length from the far block
      for (int i = 0; i < 3; i++) begin
         len = 2 + $unsigned($random(seed)) % 4;
         ldv <= 16'(len);
         ld <= 1'b1;
         tick(1);
         ld <= 1'b0;
         wr(CTRL_ADDR, (i == 2) ? (32'h4 << CTRL_SRC_LO) : 32'h0);
         wr(WIPE_LEN_ADDR, (i == 2) ? 32'h0 : 32'(len));
         wt <= 1'b1;
         tick(2);
         chk({31'h0, wq}, 32'h1);
         till(0, 1'b0);
         chk({16'h0, wet}, 32'(len));
         wt <= 1'b0;
         tick(2);
      end
      wr(CTRL_ADDR, 32'h0);
      wr(WIPE_LEN_ADDR, 32'h9);
      wt <= 1'b1;
      tick(3);
      wt <= 1'b0;
      tick(2);
      chk({31'h0, wq}, 32'h0);
      for (int r = 0; r < 2; r++) begin
         wr(CTRL_ADDR, 32'(r));
         wt <= 1'b1;
         tick(8);
         pok <= 1'b0;
         tick(1);
         pok <= 1'b1;
         tick(2);
         chk({31'h0, wq}, 32'(r));
         if (r == 0) chk({16'h0, wet}, 32'h0);
         wt <= 1'b0;
         tick(2);
      end
      $display("Test wipe done");
      wr(TRAIN_LOW_ADDR, 32'h2);
      wr(TRAIN_HIGH_ADDR, 32'h3);
      for (int k = 1; k <= 9; k += 4) begin
         wr(TRAIN_CNT_ADDR, 32'(k));
         tt <= 1'b1;
         n = 0;
         repeat (k * 5 * TK + 40) begin
            @(posedge clk);
            if (tq === 1'b1) n++;
         end
         chk(32'(n), 32'(k * 3 * TK));
         chk({31'h0, tq}, 32'h0);
         tt <= 1'b0;
         tick(1);
      end
      // Retrigger inside the high phase must drop the output at once
      tt <= 1'b1;
      till(1, 1'b1);
      tt <= 1'b0;
      tick(1);
      tt <= 1'b1;
      tick(2);
      chk({31'h0, tq}, 32'h0);
      chk({16'h0, tet}, 32'h0);
      run(1, 1'b0, n);
      chk(32'(n >= TK && n <= 2 * TK + 2), 32'h1);
      tc <= 1'b1;
      tick(1);
      tc <= 1'b0;
      tick(1);
      chk({31'h0, tq}, 32'h0);
      chk({16'h0, tet}, 32'h0);
      tt <= 1'b0;
      $display("Test train done");
      wr(GEN_HIGH_ADDR, 32'h2);
      wr(GEN_LOW_ADDR, 32'h3);
      for (int v = 0; v < 2; v++) begin
         gi <= v[0];
         gg <= 1'b1;
         tick(1);
         chk({31'h0, gq}, {31'h0, !v[0]});
         till(2, v[0]);
         run(2, v[0], n);
         run(2, !v[0], m);
         chk(32'(n), 32'(3 * TK));
         chk(32'(m), 32'(2 * TK));
         gg <= 1'b0;
         tick(1);
         chk({31'h0, gq}, 32'h0);
         tick(1);
         chk({16'h0, get}, 32'h0);
      end
      $display("Test generator done");
      print_verdict();
   end
endmodule
